// File: common/gpio_defines.svh
// Register offsets, field widths and reset values of the four-port GPIO unit
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH
`define OFS_PORT_A_OUT_DATA 8'h00
`define OFS_PORT_A_DIRECTION 8'h04
`define OFS_PORT_B_OUT_DATA 8'h0C
`define OFS_PORT_B_DIRECTION 8'h10
`define OFS_PORT_C_OUT_DATA 8'h18
`define OFS_PORT_C_DIRECTION 8'h1C
`define OFS_PORT_D_OUT_DATA 8'h24
`define OFS_PORT_D_DIRECTION 8'h28
`define OFS_IRQ_ENABLE 8'h30
`define OFS_IRQ_MASK 8'h34
`define OFS_IRQ_EDGE_SELECT 8'h38
`define OFS_IRQ_POLARITY 8'h3C
`define OFS_IRQ_MASKED_STATUS 8'h40
`define OFS_IRQ_RAW_STATUS 8'h44
`define OFS_DEBOUNCE_ENABLE 8'h48
`define OFS_IRQ_EDGE_CLEAR 8'h4C
`define OFS_PORT_A_PAD_VALUE 8'h50
`define OFS_PORT_B_PAD_VALUE 8'h54
`define OFS_PORT_C_PAD_VALUE 8'h58
`define OFS_PORT_D_PAD_VALUE 8'h5C
`define OFS_LEVEL_IRQ_SYNC_ENABLE 8'h60
`define PORT_WIDTH 8
`define PORT_COUNT 4
`define REG_RESET 8'h00
`endif

// File: common/gpio_pkg.sv
// Types shared by the four-port GPIO unit
package gpio_pkg;
  // One port's software-side state
  typedef struct packed {
    logic [7:0] out_data;
    logic [7:0] direction;
  } port_cfg_t;
  // Per-bit interrupt configuration of the first port
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] mask;
    logic [7:0] edge_sel;
    logic [7:0] polarity;
    logic [7:0] debounce;
    logic sync_level;
  } irq_cfg_t;
endpackage

// File: logic/apb_gpio_four_port.sv
// APB slave GPIO unit with four 8-bit ports and first-port interrupts
`timescale 1ns/1ps
`include "gpio_defines.svh"
// Summary of operation
// - Acts as APB slave with a 32-bit data path
// - Controls 32 pads in four 8-bit ports, each bit independent
// - Output data drives pads set as output; reads return last write
// - Direction bit 0 is input, 1 is output; reset makes all inputs
// - Pad value register returns pad for inputs, out data for outputs
// - First-port bits with enable set act as interrupt sources
// - Bits set as output raise no new interrupt
// - Mask bit 1 blocks the interrupt; 0 passes it
// - Type bit 0 gives level detection, 1 gives edge detection
// - Polarity 0 means low or falling, 1 means high or rising
// - Raw status before mask and masked status after, both read-only
// - Debounced inputs must hold for two clock periods
// - Writing 1 to clear register clears that edge interrupt
// - Interrupts stay cleared while their bit is not enabled
// - Level sync setting selects synchronised or direct level path
// - Unused addresses and bits read zero with no bus error
// - Masked interrupts combine into one output without own mask
// - Edge inputs are always synchronised before edge detection
// - Edge clear removes raw and masked status together
module apb_gpio_four_port
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads, ports A..D in bytes 0..3
  input wire logic [31:0] pad_in,
  output logic [31:0] pad_out,
  output logic [31:0] pad_oe_n,
  // Combined interrupt
  output logic irq
);
  localparam int W = `PORT_WIDTH;
  localparam int N = `PORT_COUNT;

  port_cfg_t port_cfg [N];
  irq_cfg_t icfg;
  logic [W-1:0] edge_status;
  logic [31:0] pad_meta;
  logic [31:0] pad_sync;
  logic [W-1:0] deb_stage;
  logic [W-1:0] deb_value;
  logic [W-1:0] prev_sample;

  // Access decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && !penable && !pwrite;
  wire [7:0] wr_b = pwdata[7:0];

  // Double synchroniser on every pad input
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pad_meta <= 32'h0;
      pad_sync <= 32'h0;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  // Debounce: value accepted only after two equal samples
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      deb_stage <= 8'h00;
      deb_value <= 8'h00;
    end else begin
      deb_stage <= pad_sync[W-1:0];
      deb_value <= (deb_stage == pad_sync[W-1:0]) ? deb_stage : deb_value;
    end
  end

  // Interrupt source selection
  wire [W-1:0] src_filt = (icfg.debounce & deb_value) | (~icfg.debounce & pad_sync[W-1:0]);
  wire [W-1:0] src_direct = (icfg.debounce & deb_value) | (~icfg.debounce & pad_in[W-1:0]);
  wire [W-1:0] level_src = icfg.sync_level ? src_filt : src_direct;
  wire [W-1:0] active_mask = icfg.enable & ~port_cfg[0].direction;
  wire [W-1:0] level_active = ~(level_src ^ icfg.polarity);
  wire [W-1:0] rise = src_filt & ~prev_sample;
  wire [W-1:0] fall = ~src_filt & prev_sample;
  wire [W-1:0] edge_hit = active_mask & icfg.edge_sel & (icfg.polarity & rise | ~icfg.polarity & fall);
  wire [W-1:0] clear_bits = (wr_en && paddr == `OFS_IRQ_EDGE_CLEAR) ? wr_b : 8'h00;
  wire [W-1:0] raw_status = (edge_status & icfg.edge_sel & icfg.enable) |
                            (level_active & ~icfg.edge_sel & active_mask);
  wire [W-1:0] masked_status = raw_status & ~icfg.mask;
  wire [W-1:0] next_edge_status = edge_hit | (edge_status & ~clear_bits & icfg.enable);

  // Edge status: set wins over clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_sample <= 8'h00;
      edge_status <= 8'h00;
    end else begin
      prev_sample <= src_filt;
      edge_status <= next_edge_status;
    end
  end

  // Register writes
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_port
      wire [7:0] ofs_dr = (g == 0) ? `OFS_PORT_A_OUT_DATA : (g == 1) ? `OFS_PORT_B_OUT_DATA :
                          (g == 2) ? `OFS_PORT_C_OUT_DATA : `OFS_PORT_D_OUT_DATA;
      wire [7:0] ofs_ddr = (g == 0) ? `OFS_PORT_A_DIRECTION : (g == 1) ? `OFS_PORT_B_DIRECTION :
                           (g == 2) ? `OFS_PORT_C_DIRECTION : `OFS_PORT_D_DIRECTION;
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          port_cfg[g] <= '0;
        end else if (wr_en && paddr == ofs_dr) begin
          port_cfg[g].out_data <= wr_b;
        end else if (wr_en && paddr == ofs_ddr) begin
          port_cfg[g].direction <= wr_b;
        end
      end
      // Pad drive from registers; enable low while driving
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          pad_out[g*W +: W] <= 8'h00;
          pad_oe_n[g*W +: W] <= 8'hFF;
        end else begin
          pad_out[g*W +: W] <= port_cfg[g].out_data;
          pad_oe_n[g*W +: W] <= ~port_cfg[g].direction;
        end
      end
      // Pad value readback
      wire [W-1:0] pad_value = (port_cfg[g].direction & port_cfg[g].out_data) |
                               (~port_cfg[g].direction & pad_sync[g*W +: W]);
      // Each port's pads follow its own registers one cycle later
      chk_port_drive: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> pad_out[g*W +: W] == $past(port_cfg[g].out_data))
        else $error("port pad drive wrong");
      // Each port's enables follow its own direction bits, low when driving
      chk_port_oe: assert property (@(posedge clock) disable iff (!nrst)
        1'b1 |=> pad_oe_n[g*W +: W] == ~$past(port_cfg[g].direction))
        else $error("port enable wrong");
    end
  endgenerate

  // Interrupt configuration registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      icfg <= '0;
    end else if (wr_en) begin
      if (paddr == `OFS_IRQ_ENABLE) begin
        icfg.enable <= wr_b;
      end else if (paddr == `OFS_IRQ_MASK) begin
        icfg.mask <= wr_b;
      end else if (paddr == `OFS_IRQ_EDGE_SELECT) begin
        icfg.edge_sel <= wr_b;
      end else if (paddr == `OFS_IRQ_POLARITY) begin
        icfg.polarity <= wr_b;
      end else if (paddr == `OFS_DEBOUNCE_ENABLE) begin
        icfg.debounce <= wr_b;
      end else if (paddr == `OFS_LEVEL_IRQ_SYNC_ENABLE) begin
        icfg.sync_level <= pwdata[0];
      end
    end
  end

  // Read mux; unmapped reads give zero
  wire [7:0] rd_byte =
    (paddr == `OFS_PORT_A_OUT_DATA) ? port_cfg[0].out_data :
    (paddr == `OFS_PORT_A_DIRECTION) ? port_cfg[0].direction :
    (paddr == `OFS_PORT_B_OUT_DATA) ? port_cfg[1].out_data :
    (paddr == `OFS_PORT_B_DIRECTION) ? port_cfg[1].direction :
    (paddr == `OFS_PORT_C_OUT_DATA) ? port_cfg[2].out_data :
    (paddr == `OFS_PORT_C_DIRECTION) ? port_cfg[2].direction :
    (paddr == `OFS_PORT_D_OUT_DATA) ? port_cfg[3].out_data :
    (paddr == `OFS_PORT_D_DIRECTION) ? port_cfg[3].direction :
    (paddr == `OFS_IRQ_ENABLE) ? icfg.enable :
    (paddr == `OFS_IRQ_MASK) ? icfg.mask :
    (paddr == `OFS_IRQ_EDGE_SELECT) ? icfg.edge_sel :
    (paddr == `OFS_IRQ_POLARITY) ? icfg.polarity :
    (paddr == `OFS_IRQ_MASKED_STATUS) ? masked_status :
    (paddr == `OFS_IRQ_RAW_STATUS) ? raw_status :
    (paddr == `OFS_DEBOUNCE_ENABLE) ? icfg.debounce :
    (paddr == `OFS_PORT_A_PAD_VALUE) ? g_port[0].pad_value :
    (paddr == `OFS_PORT_B_PAD_VALUE) ? g_port[1].pad_value :
    (paddr == `OFS_PORT_C_PAD_VALUE) ? g_port[2].pad_value :
    (paddr == `OFS_PORT_D_PAD_VALUE) ? g_port[3].pad_value :
    (paddr == `OFS_LEVEL_IRQ_SYNC_ENABLE) ? {7'h00, icfg.sync_level} :
    `REG_RESET;

  // Bus answers and interrupt output
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (rd_en) begin
        prdata <= {24'h000000, rd_byte};
      end
      pready <= psel && !penable;
      pslverr <= 1'b0;
      irq <= |masked_status;
    end
  end

  // Checks
  sequence s_rise_seen;
    icfg.edge_sel[0] && icfg.polarity[0] && active_mask[0] && rise[0];
  endsequence

  // Falling transition on an enabled, falling-edge bit
  sequence s_fall_seen;
    icfg.edge_sel[0] && !icfg.polarity[0] && active_mask[0] && fall[0];
  endsequence

  // Bus setup phase
  sequence s_apb_setup;
    psel && !penable;
  endsequence

  // Bus access phase
  sequence s_apb_access;
    psel && penable;
  endsequence

  chk_output_drive: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> pad_out[7:0] == $past(port_cfg[0].out_data)) else $error("pad drive wrong");
  chk_direction_oe: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> pad_oe_n[7:0] == ~$past(port_cfg[0].direction)) else $error("oe wrong");
  chk_out_no_irq: assert property (@(posedge clock) disable iff (!nrst)
    port_cfg[0].direction[0] |-> !edge_hit[0]) else $error("output bit raised irq");
  chk_mask_blocks: assert property (@(posedge clock) disable iff (!nrst)
    icfg.mask == 8'hFF |=> !irq) else $error("masked irq passed");
  chk_edge_sets: assert property (@(posedge clock) disable iff (!nrst)
    s_rise_seen |=> edge_status[0]) else $error("edge not latched");
  chk_edge_clear: assert property (@(posedge clock) disable iff (!nrst)
    clear_bits[0] && !edge_hit[0] |=> !edge_status[0]) else $error("edge not cleared");
  chk_disabled_clear: assert property (@(posedge clock) disable iff (!nrst)
    !icfg.enable[0] |-> !raw_status[0]) else $error("disabled bit pending");
  chk_irq_combine: assert property (@(posedge clock) disable iff (!nrst)
    (masked_status != 8'h00) |=> irq) else $error("irq not combined");
  chk_no_error: assert property (@(posedge clock) disable iff (!nrst)
    psel ##1 psel && penable |-> !pslverr) else $error("slave error seen");
  chk_debounce_hold: assert property (@(posedge clock) disable iff (!nrst)
    $changed(deb_value) |-> $past(deb_stage) == deb_value) else $error("debounce glitch");

  // Ready answers every setup phase in the following cycle
  chk_pready_pulse: assert property (@(posedge clock) disable iff (!nrst)
    s_apb_setup |=> pready) else $error("ready missing after setup");

  // Ready lasts one cycle only
  chk_pready_drop: assert property (@(posedge clock) disable iff (!nrst)
    s_apb_access |=> !pready) else $error("ready held too long");

  // No ready while the unit is not selected
  chk_pready_idle: assert property (@(posedge clock) disable iff (!nrst)
    !psel |=> !pready) else $error("ready without select");

  // Upper read bits are always zero during an answer
  chk_read_upper: assert property (@(posedge clock) disable iff (!nrst)
    pready |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");

  // Read data is captured from the decoded register at setup
  chk_read_capture: assert property (@(posedge clock) disable iff (!nrst)
    rd_en |=> prdata[7:0] == $past(rd_byte)) else $error("read data not captured");

  // Read data stays put between reads
  chk_read_hold: assert property (@(posedge clock) disable iff (!nrst)
    !rd_en |=> $stable(prdata)) else $error("read data moved");

  // A hole in the map reads zero
  chk_hole_zero: assert property (@(posedge clock) disable iff (!nrst)
    rd_en && paddr == 8'h08 |=> prdata == 32'h0) else $error("hole read nonzero");

  // Sync setting reads back as a single bit
  chk_sync_width: assert property (@(posedge clock) disable iff (!nrst)
    rd_en && paddr == `OFS_LEVEL_IRQ_SYNC_ENABLE |=> prdata[31:1] == 31'h0)
    else $error("sync readback too wide");

  // First pad flop follows the pin
  chk_meta_capture: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> pad_meta == $past(pad_in)) else $error("first sync stage wrong");

  // Second pad flop follows the first
  chk_sync_pipe: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> pad_sync == $past(pad_meta)) else $error("second sync stage wrong");

  // Output data write lands in the first port
  chk_write_data: assert property (@(posedge clock) disable iff (!nrst)
    wr_en && paddr == `OFS_PORT_A_OUT_DATA |=> port_cfg[0].out_data == $past(wr_b))
    else $error("out data write lost");

  // Direction write lands in the first port
  chk_write_dir: assert property (@(posedge clock) disable iff (!nrst)
    wr_en && paddr == `OFS_PORT_A_DIRECTION |=> port_cfg[0].direction == $past(wr_b))
    else $error("direction write lost");

  // Enable write lands in the interrupt setup
  chk_enable_write: assert property (@(posedge clock) disable iff (!nrst)
    wr_en && paddr == `OFS_IRQ_ENABLE |=> icfg.enable == $past(wr_b))
    else $error("enable write lost");

  // Masked status never shows a bit that raw status lacks
  chk_masked_subset: assert property (@(posedge clock) disable iff (!nrst)
    (masked_status & ~raw_status) == 8'h00) else $error("masked outside raw");

  // A mask bit hides its own bit
  chk_mask_per_bit: assert property (@(posedge clock) disable iff (!nrst)
    icfg.mask[0] |-> !masked_status[0]) else $error("mask bit ignored");

  // Level bit follows its active level
  chk_level_follows: assert property (@(posedge clock) disable iff (!nrst)
    icfg.enable[1] && !icfg.edge_sel[1] && !port_cfg[0].direction[1] |->
    raw_status[1] == (level_src[1] == icfg.polarity[1])) else $error("level not followed");

  // Level bit driven as output shows nothing
  chk_out_level_gate: assert property (@(posedge clock) disable iff (!nrst)
    port_cfg[0].direction[1] && !icfg.edge_sel[1] |-> !raw_status[1])
    else $error("output level pending");

  // Level bits never produce edge hits
  chk_level_no_edge: assert property (@(posedge clock) disable iff (!nrst)
    !icfg.edge_sel[0] |-> !edge_hit[0]) else $error("edge hit on level bit");

  // Pending edge stays until cleared or disabled
  chk_edge_hold: assert property (@(posedge clock) disable iff (!nrst)
    edge_status[0] && !clear_bits[0] && icfg.enable[0] |=> edge_status[0])
    else $error("edge status lost");

  // Falling edge latches for low polarity
  chk_fall_sets: assert property (@(posedge clock) disable iff (!nrst)
    s_fall_seen |=> edge_status[0]) else $error("falling edge not latched");

  // Falling edge ignored for high polarity
  chk_rise_only: assert property (@(posedge clock) disable iff (!nrst)
    icfg.edge_sel[0] && icfg.polarity[0] && fall[0] && !edge_status[0] |=> !edge_status[0])
    else $error("wrong edge latched");

  // Disabled bit drops its pending edge
  chk_disabled_edge: assert property (@(posedge clock) disable iff (!nrst)
    !icfg.enable[0] |=> !edge_status[0]) else $error("disabled edge kept");

  // Clear drops raw status as well
  chk_edge_raw: assert property (@(posedge clock) disable iff (!nrst)
    clear_bits[0] && !edge_hit[0] && icfg.edge_sel[0] |=> !raw_status[0])
    else $error("raw status not cleared");

  // Sync on selects the synchronised level path
  chk_level_sync_on: assert property (@(posedge clock) disable iff (!nrst)
    icfg.sync_level |-> level_src == src_filt) else $error("sync path not used");

  // Sync off selects the direct level path
  chk_level_sync_off: assert property (@(posedge clock) disable iff (!nrst)
    !icfg.sync_level |-> level_src == src_direct) else $error("direct path not used");

  // Two equal samples settle the debounced value
  chk_debounce_settle: assert property (@(posedge clock) disable iff (!nrst)
    deb_stage == pad_sync[W-1:0] |=> deb_value == $past(deb_stage))
    else $error("debounce did not settle");

  // Unequal samples leave the debounced value alone
  chk_debounce_block: assert property (@(posedge clock) disable iff (!nrst)
    deb_stage != pad_sync[W-1:0] |=> $stable(deb_value)) else $error("debounce let glitch");

  // No masked interrupt means the combined line falls
  chk_irq_low: assert property (@(posedge clock) disable iff (!nrst)
    masked_status == 8'h00 |=> !irq) else $error("irq without source");

  // Bus error never raised
  chk_slverr_low: assert property (@(posedge clock) disable iff (!nrst)
    s_apb_access |=> !pslverr) else $error("error after access");
endmodule

// File: test/pad_model.sv
// Pad ring model: output pads follow the unit, input pads follow the bench
`timescale 1ns/1ps
module pad_model (
  // From the unit
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe_n,
  // Level applied from outside on undriven pads
  input wire logic [31:0] ext_level,
  // Back to the unit
  output logic [31:0] pad_in
);
  // Each pad resolves on its own from its enable
  assign pad_in = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
endmodule

// File: test/apb_gpio_four_port_test.sv
// Self-checking bench of the four-port APB GPIO unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module apb_gpio_four_port_test;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pad_in, pad_out, pad_oe_n, ext;
  int n_errors = 0;
  int cmp_count = 0;
  // Unit and its pads
  apb_gpio_four_port u_apb_gpio_four_port (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .irq(irq));
  pad_model u_pad_model (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext),
    .pad_in(pad_in));
  // Clock at 100 MHz
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // Verdict and end of run
  task summarize();
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One full-word APB transfer, setup then access
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(negedge clock); psel = 1; pwrite = w; paddr = a; pwdata = d;
    @(negedge clock); penable = 1;
    for (int k = 0; k < 4 && pready !== 1'b1; k++) @(negedge clock);
    `CHK("pready", 1'b1, pready)
    `CHK("pslverr", 1'b0, pslverr)
    r = prdata;
    @(posedge clock); @(negedge clock); psel = 0; penable = 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1, a, d, r);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(0, a, 32'h0, r);
    `CHK($sformatf("reg_%h", a), e, r)
  endtask
  // Reset state of every word location from 0x00 to 0x64, mapped or not
  task t_reset();
    `CHK("pad_oe_n", 32'hFFFFFFFF, pad_oe_n)
    `CHK("irq", 1'b0, irq)
    for (int a = 0; a <= 8'h64; a += 4) rc(a[7:0], 32'h0);
  endtask
  // Per-port output data, direction and pad readback
  task t_ports();
    logic [7:0] od, dr;
    for (int p = 0; p < 4; p++) begin
      od = 8'hA5 ^ p[7:0];
      dr = 8'h3C ^ p[7:0];
      wr(p * 12, {24'hFFFFFF, od});
      wr(p * 12 + 4, {24'h0, dr});
      rc(p * 12, {24'h0, od});
      rc(p * 12 + 4, {24'h0, dr});
      ext[8 * p +: 8] = 8'h96;
      repeat (4) @(negedge clock);
      `CHK("pad_oe_n", ~dr, pad_oe_n[8 * p +: 8])
      `CHK("pad_out", od, pad_out[8 * p +: 8])
      rc(8'h50 + 4 * p, {24'h0, (od & dr) | (8'h96 & ~dr)});
    end
    wr(8'h04, 32'h0);
    ext = 32'h0;
  endtask
  // Edge interrupt on bit 0: set, hold, mask, clear, polarity
  task t_edge();
    wr(8'h38, 32'h01); wr(8'h3C, 32'h01); wr(8'h30, 32'h01);
    ext[0] = 1;
    repeat (6) @(negedge clock);
    `CHK("irq", 1'b1, irq)
    ext[0] = 0;
    rc(8'h40, 32'h01);
    rc(8'h44, 32'h01);
    wr(8'h34, 32'h01);
    rc(8'h40, 32'h0);
    `CHK("irq", 1'b0, irq)
    rc(8'h44, 32'h01);
    wr(8'h34, 32'h0);
    wr(8'h4C, 32'hFE);
    rc(8'h44, 32'h01);
    wr(8'h4C, 32'h01);
    rc(8'h44, 32'h0);
    rc(8'h40, 32'h0);
    wr(8'h3C, 32'h0);
    ext[0] = 1;
    repeat (6) @(negedge clock);
    rc(8'h44, 32'h0);
    ext[0] = 0;
    repeat (6) @(negedge clock);
    rc(8'h44, 32'h01);
    wr(8'h30, 32'h0);
    rc(8'h44, 32'h0);
  endtask
  // Level interrupt on bit 1, direction gating and sync setting
  task t_level();
    ext[1] = 1;
    wr(8'h38, 32'h0); wr(8'h3C, 32'h0); wr(8'h30, 32'h02);
    rc(8'h44, 32'h0);
    ext[1] = 0;
    repeat (4) @(negedge clock);
    rc(8'h44, 32'h02);
    wr(8'h4C, 32'h02);
    rc(8'h44, 32'h02);
    wr(8'h04, 32'h02);
    repeat (4) @(negedge clock);
    rc(8'h44, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h60, 32'h1);
    rc(8'h60, 32'h1);
    wr(8'h3C, 32'h02);
    rc(8'h44, 32'h0);
    ext[1] = 1;
    repeat (6) @(negedge clock);
    rc(8'h44, 32'h02);
    wr(8'h30, 32'h0);
  endtask
  // Debounced rising edge on bit 2: short pulse dropped, long one kept
  task t_debounce();
    wr(8'h48, 32'h04); wr(8'h38, 32'h04); wr(8'h3C, 32'h04); wr(8'h30, 32'h04);
    ext[2] = 1;
    @(negedge clock); ext[2] = 0;
    repeat (8) @(negedge clock);
    rc(8'h44, 32'h0);
    ext[2] = 1;
    repeat (8) @(negedge clock);
    rc(8'h44, 32'h04);
  endtask
  // Watchdog against a hung handshake
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0; ext = 32'h0;
    repeat (4) @(negedge clock);
    nrst = 1;
    t_reset();
    t_ports();
    t_edge();
    t_level();
    t_debounce();
    summarize();
  end
endmodule
